// *** hdl/uic_pkg.sv ***
// uic_pkg: register map, field positions and carrier structs for the uart irq/ir control block
package uic_pkg;

  // ---------------------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  UIC_ADDR_CTRL3    = 8'h00;  // uart_control_three
  localparam logic [7:0]  UIC_ADDR_CTRL4    = 8'h04;  // uart_control_four
  localparam logic [7:0]  UIC_ADDR_STATUS   = 8'h08;  // event flags, write one to clear
  localparam logic [7:0]  UIC_ADDR_BAUD     = 8'h0c;  // auto-baud count in, read only
  localparam logic [7:0]  UIC_ADDR_BRM      = 8'h10;  // selected modulator value, read only
  localparam logic [7:0]  UIC_ADDR_PRESET_A = 8'h14;  // baud_modulator_reg_a preset
  localparam logic [7:0]  UIC_ADDR_PRESET_B = 8'h18;  // baud_modulator_reg_b preset
  localparam logic [7:0]  UIC_ADDR_MATCH_A  = 8'h1c;  // dividend/remainder key for preset a
  localparam logic [7:0]  UIC_ADDR_MATCH_B  = 8'h20;  // dividend/remainder key for preset b

  // ---------------------------------------------------------------------------
  // control three fields (low part only)
  // ---------------------------------------------------------------------------
  localparam int UIC_C3_BAUD_PRESET_EN = 0;
  localparam int UIC_C3_IR_TX_POL      = 1;
  localparam int UIC_C3_REF_CLK_IS_30MHZ          = 2;
  localparam int UIC_C3_REF_CLK_IS_25MHZ          = 3;
  localparam int UIC_C3_RX_EDGE_IEN    = 4;
  localparam int UIC_C3_IR_PULSE_IEN   = 5;
  localparam logic [31:0] UIC_C3_WMASK = 32'h0000_003f;

  // ---------------------------------------------------------------------------
  // control four fields
  // ---------------------------------------------------------------------------
  localparam int UIC_C4_RX_READY_IEN   = 0;
  localparam int UIC_C4_OVERRUN_IEN    = 1;
  localparam int UIC_C4_BREAK_IEN      = 2;
  localparam int UIC_C4_TX_DONE_IEN    = 3;
  localparam int UIC_C4_VOTE_CLK_SEL   = 5;
  localparam int UIC_C4_REF_CLK_IS_16MHZ          = 6;
  localparam int UIC_C4_START_BIT_IEN  = 7;
  localparam int UIC_C4_IR_IEN         = 8;
  localparam int UIC_C4_IR_RX_POL      = 9;
  localparam int UIC_C4_THR_LSB        = 10;
  localparam int UIC_C4_THR_MSB        = 15;
  localparam logic [31:0] UIC_C4_WMASK = 32'h0000_ffef;  // bit 4 and 31..16 reserved
  localparam logic [31:0] UIC_CTRL_RST = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // status flag positions
  // ---------------------------------------------------------------------------
  localparam int UIC_ST_IR_PULSE  = 0;
  localparam int UIC_ST_RX_EDGE   = 1;
  localparam int UIC_ST_START_BIT = 2;
  localparam int UIC_ST_IR_EVENT  = 3;
  localparam int UIC_ST_NUM       = 4;

  // ---------------------------------------------------------------------------
  // flow control, ir timing, reference divider
  // ---------------------------------------------------------------------------
  localparam logic [5:0] UIC_THR_MAX     = 6'h20;  // 32 characters
  localparam logic [5:0] UIC_FIFO_DEPTH  = 6'h20;
  localparam logic [3:0] UIC_IR_PULSE_LEN = 4'h3;  // 3 of 16 sample ticks
  localparam logic [3:0] UIC_IR_LAST_TICK = 4'hf;
  localparam logic [2:0] UIC_DIV_RST      = 3'h0;  // divide by 6
  localparam logic [3:0] UIC_REF_VOTE_MIN = 4'h2;  // ref-clock vote count for a valid pulse
  localparam logic [1:0] UIC_RESP_OKAY    = 2'h0;
  localparam logic [1:0] UIC_RESP_SLVERR  = 2'h2;

  // ---------------------------------------------------------------------------
  // carrier structs
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic rx_data_ready_flag;
    logic rx_overrun_flag;
    logic break_detect_flag;
    logic tx_complete_flag;
  } uic_flags_s;

  typedef struct packed {
    logic [11:0] dividend;
    logic [3:0]  remainder;
  } uic_baud_s;

endpackage : uic_pkg

// *** hdl/uic_top.sv ***
// uic_top: uart interrupt enables, ir encode/decode, ref divider, baud preset, cts threshold
//
// How it works
// [R1] ir-pulse irq enable set: pulse seen on receive pin raises irq; clear keeps off.
// [R2] rx-edge irq enable set: falling edge on receive pin raises irq; clear disables.
// [R3] control three bit 3 flags 25 MHz reference, bit 2 flags 30 MHz.
// [R4] control four bit 6 flags a 16 MHz reference clock.
// [R5] reference tick comes from peripheral clock through programmable divider.
// [R6] tx polarity clear: positive 3/16 pulse per zero; set: negative pulse.
// [R7] preset enable clear: auto-baud remainder of count divided by 16 ignored.
// [R8] preset enable set: dividend and remainder select matching preset register.
// [R9] no preset match: modulator gets dividend minus one.
// [R10] six-bit field 15..10 sets rx fifo level deasserting cts, 0..32.
// [R11] after cts drops the rx fifo keeps accepting until full.
// [R12] rx polarity clear: negative 3/16 pulse is zero; set: positive pulse is zero.
// [R13] bit 8 enables the serial infrared interrupt.
// [R14] receiver sets start-bit flag on start bit; bit 7 lets it interrupt.
// [R15] vote clock select: set uses reference tick, clear uses 16x sample tick.
// [R16] bit 3 lets tx-complete flag drive active-low tx irq line.
// [R17] bit 2 lets break flag drive active-low control irq line.
// [R18] bit 1 lets overrun flag drive active-low control irq line.
// [R19] bit 0 lets rx-ready flag drive active-low rx irq line.
// [R20] control four bit 4 and bits 31..16 always read zero.
// [R21] irq lines are OR of enabled sources, active low, next clock effect.
`timescale 1ns/1ps
module uic_top
  import uic_pkg::*;
(
  // clock and reset
  input  wire logic                i_core_clk,
  input  wire logic                i_sys_rst,
  // axi4-lite write address / data / response
  input  wire logic [7:0]          i_awaddr,
  input  wire logic                i_awvalid,
  output      logic                o_awready,
  input  wire logic [31:0]         i_wdata,
  input  wire logic [3:0]          i_wstrb,
  input  wire logic                i_wvalid,
  output      logic                o_wready,
  output      logic [1:0]          o_bresp,
  output      logic                o_bvalid,
  input  wire logic                i_bready,
  // axi4-lite read address / data
  input  wire logic [7:0]          i_araddr,
  input  wire logic                i_arvalid,
  output      logic                o_arready,
  output      logic [31:0]         o_rdata,
  output      logic [1:0]          o_rresp,
  output      logic                o_rvalid,
  input  wire logic                i_rready,
  // reference divider select, 16x sample tick from the baud generator
  input  wire logic [2:0]          i_ref_div_sel,
  input  wire logic                i_sample_tick,
  output      logic                o_ref_tick,
  // serial / infrared line
  input  wire logic                i_rx_pin,
  input  wire logic                i_tx_data,
  input  wire logic                i_ir_mode,
  output      logic                o_ir_tx,
  output      logic                o_ir_rx_data,
  // receiver side events and fifo level
  input  wire logic                i_start_bit,
  input  wire uic_pkg::uic_flags_s i_flags,
  input  wire logic [5:0]          i_rx_fifo_level,
  output      logic                o_cts_n,
  output      logic                o_rx_fifo_accept,
  // auto-baud detection
  input  wire logic                i_baud_done,
  input  wire logic [15:0]         i_baud_count,
  output      logic                o_brm_load,
  output      logic [15:0]         o_baud_rate_modulator,
  // reference indications and interrupt lines
  output      logic [2:0]          o_ref_clk_sel,
  output      logic                o_tx_irq_line_n,
  output      logic                o_ctrl_irq_line_n,
  output      logic                o_rx_irq_line_n,
  output      logic                o_async_irq_n
);

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  logic [31:0]             ctrl3_r, ctrl4_r;
  logic [15:0]             preset_a_r, preset_b_r, match_a_r, match_b_r;
  logic [15:0]             baud_r;
  logic [UIC_ST_NUM-1:0]   status_r;
  logic                    aw_held_r, w_held_r;
  logic [7:0]              awaddr_r;
  logic [31:0]             wdata_r;
  logic [3:0]              wstrb_r;
  logic [2:0]              div_cnt_r;
  logic                    rx_prev_r;
  logic [3:0]              tx_phase_r, vote_cnt_r;
  logic                    ir_rx_r;
  logic                    wr_fire;
  logic [31:0]             wmask;
  logic [UIC_ST_NUM-1:0]   st_set, st_clr;
  logic                    ir_pulse_raw, vote_tick;
  logic [2:0]              div_last;
  uic_baud_s               bcnt;

  // ---------------------------------------------------------------------------
  // axi4-lite write path: address and data taken in either order
  // ---------------------------------------------------------------------------
  assign o_awready = !aw_held_r && !o_bvalid;
  assign o_wready  = !w_held_r && !o_bvalid;
  assign wr_fire   = aw_held_r && w_held_r && !o_bvalid;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      o_bvalid  <= 1'b0;
      o_bresp   <= UIC_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= i_wdata;
        wstrb_r  <= i_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= (awaddr_r <= UIC_ADDR_MATCH_B && awaddr_r[1:0] == 2'h0) ?
                     UIC_RESP_OKAY : UIC_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // byte-lane mask from the strobes
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wstrb_r[b]}};
    end
  end

  // control registers; reserved bits never stored so they read zero
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl3_r    <= UIC_CTRL_RST;
      ctrl4_r    <= UIC_CTRL_RST;
      preset_a_r <= 16'h0000;
      preset_b_r <= 16'h0000;
      match_a_r  <= 16'h0000;
      match_b_r  <= 16'h0000;
    end else if (wr_fire) begin
      case (awaddr_r)
        UIC_ADDR_CTRL3:
          ctrl3_r <= (ctrl3_r & ~(wmask & UIC_C3_WMASK)) | (wdata_r & wmask & UIC_C3_WMASK);
        UIC_ADDR_CTRL4:
          ctrl4_r <= (ctrl4_r & ~(wmask & UIC_C4_WMASK)) | (wdata_r & wmask & UIC_C4_WMASK); // [R20]
        UIC_ADDR_PRESET_A: preset_a_r <= (preset_a_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
        UIC_ADDR_PRESET_B: preset_b_r <= (preset_b_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
        UIC_ADDR_MATCH_A:  match_a_r  <= (match_a_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
        UIC_ADDR_MATCH_B:  match_b_r  <= (match_b_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // axi4-lite read path: answer one cycle after the address is taken
  // ---------------------------------------------------------------------------
  assign o_arready = !o_rvalid;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= UIC_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rresp  <= UIC_RESP_OKAY;
      case (i_araddr)
        UIC_ADDR_CTRL3:    o_rdata <= ctrl3_r;
        UIC_ADDR_CTRL4:    o_rdata <= ctrl4_r;                  // [R20]
        UIC_ADDR_STATUS:   o_rdata <= {28'h0000000, status_r};
        UIC_ADDR_BAUD:     o_rdata <= {16'h0000, baud_r};
        UIC_ADDR_BRM:      o_rdata <= {16'h0000, o_baud_rate_modulator};
        UIC_ADDR_PRESET_A: o_rdata <= {16'h0000, preset_a_r};
        UIC_ADDR_PRESET_B: o_rdata <= {16'h0000, preset_b_r};
        UIC_ADDR_MATCH_A:  o_rdata <= {16'h0000, match_a_r};
        UIC_ADDR_MATCH_B:  o_rdata <= {16'h0000, match_b_r};
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= UIC_RESP_SLVERR;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // reference clock indication and divider
  // ---------------------------------------------------------------------------
  assign o_ref_clk_sel = {ctrl4_r[UIC_C4_REF_CLK_IS_16MHZ], ctrl3_r[UIC_C3_REF_CLK_IS_25MHZ],
                          ctrl3_r[UIC_C3_REF_CLK_IS_30MHZ]}; // [R3] [R4]

  // select 000..110 gives divide by 6,5,4,3,2,1,7; 111 treated as 7
  always_comb begin
    case (i_ref_div_sel)
      3'h0:    div_last = 3'h5;
      3'h1:    div_last = 3'h4;
      3'h2:    div_last = 3'h3;
      3'h3:    div_last = 3'h2;
      3'h4:    div_last = 3'h1;
      3'h5:    div_last = 3'h0;
      default: div_last = 3'h6;
    endcase
  end

  // one-cycle tick keeps everything on the core clock, no derived clock net
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_cnt_r  <= UIC_DIV_RST;
      o_ref_tick <= 1'b0;
    end else if (div_cnt_r >= div_last) begin
      div_cnt_r  <= 3'h0;                                      // [R5]
      o_ref_tick <= 1'b1;
    end else begin
      div_cnt_r  <= div_cnt_r + 3'h1;
      o_ref_tick <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // infrared transmit encoder: 3 of 16 sample ticks per zero bit
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_phase_r <= 4'h0;
      o_ir_tx    <= 1'b0;
    end else begin
      if (i_sample_tick) begin
        tx_phase_r <= (tx_phase_r == UIC_IR_LAST_TICK) ? 4'h0 : tx_phase_r + 4'h1;
      end
      if (!i_ir_mode) begin
        o_ir_tx <= i_tx_data;
      end else begin
        // pulse only for zero bits, idle level otherwise
        o_ir_tx <= ((!i_tx_data && tx_phase_r < UIC_IR_PULSE_LEN) ^
                    ctrl3_r[UIC_C3_IR_TX_POL]);               // [R6]
      end
    end
  end

  // ---------------------------------------------------------------------------
  // infrared receive decoder and vote logic
  // ---------------------------------------------------------------------------
  assign ir_pulse_raw = i_rx_pin ^ !ctrl4_r[UIC_C4_IR_RX_POL]; // [R12]
  assign vote_tick    = ctrl4_r[UIC_C4_VOTE_CLK_SEL] ? o_ref_tick : i_sample_tick; // [R15]

  // pulse must persist for the vote count to be taken as a zero
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      vote_cnt_r <= 4'h0;
      ir_rx_r    <= 1'b1;
    end else if (!ir_pulse_raw) begin
      vote_cnt_r <= 4'h0;
      ir_rx_r    <= 1'b1;
    end else if (vote_tick) begin
      if (vote_cnt_r != UIC_IR_LAST_TICK) begin
        vote_cnt_r <= vote_cnt_r + 4'h1;
      end
      if (vote_cnt_r + 4'h1 >= UIC_REF_VOTE_MIN) begin
        ir_rx_r <= 1'b0;                                       // [R12] [R15]
      end
    end
  end
  assign o_ir_rx_data = i_ir_mode ? ir_rx_r : i_rx_pin;

  // ---------------------------------------------------------------------------
  // event flags: hardware set wins over write-one-to-clear
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_prev_r <= 1'b1;
    end else begin
      rx_prev_r <= i_rx_pin;
    end
  end

  always_comb begin
    st_set = '0;
    st_set[UIC_ST_IR_PULSE]  = i_ir_mode && ir_pulse_raw;        // [R1]
    st_set[UIC_ST_RX_EDGE]   = rx_prev_r && !i_rx_pin;          // [R2]
    st_set[UIC_ST_START_BIT] = i_start_bit;                     // [R14]
    st_set[UIC_ST_IR_EVENT]  = i_ir_mode && !ir_rx_r;            // [R13]
    st_clr = (wr_fire && awaddr_r == UIC_ADDR_STATUS && wstrb_r[0]) ?
             wdata_r[UIC_ST_NUM-1:0] : '0;
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~st_clr) | st_set;
    end
  end

  // ---------------------------------------------------------------------------
  // interrupt lines, active low
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_tx_irq_line_n   <= 1'b1;
      o_ctrl_irq_line_n <= 1'b1;
      o_rx_irq_line_n   <= 1'b1;
      o_async_irq_n     <= 1'b1;
    end else begin
      o_tx_irq_line_n   <= !(i_flags.tx_complete_flag && ctrl4_r[UIC_C4_TX_DONE_IEN]); // [R16] [R21]
      o_ctrl_irq_line_n <= !((i_flags.break_detect_flag && ctrl4_r[UIC_C4_BREAK_IEN]) || // [R17]
                             (i_flags.rx_overrun_flag && ctrl4_r[UIC_C4_OVERRUN_IEN])); // [R18]
      o_rx_irq_line_n   <= !(i_flags.rx_data_ready_flag && ctrl4_r[UIC_C4_RX_READY_IEN]); // [R19]
      o_async_irq_n     <= !((status_r[UIC_ST_IR_PULSE] && ctrl3_r[UIC_C3_IR_PULSE_IEN]) || // [R1]
                             (status_r[UIC_ST_RX_EDGE] && ctrl3_r[UIC_C3_RX_EDGE_IEN]) ||   // [R2]
                             (status_r[UIC_ST_START_BIT] && ctrl4_r[UIC_C4_START_BIT_IEN]) || // [R14]
                             (status_r[UIC_ST_IR_EVENT] && ctrl4_r[UIC_C4_IR_IEN]));        // [R13]
    end
  end

  // ---------------------------------------------------------------------------
  // cts threshold; reserved codes above 32 clamp to 32
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cts_n <= 1'b1;
    end else begin
      o_cts_n <= (i_rx_fifo_level >= ((ctrl4_r[UIC_C4_THR_MSB:UIC_C4_THR_LSB] > UIC_THR_MAX) ?
                  UIC_THR_MAX : ctrl4_r[UIC_C4_THR_MSB:UIC_C4_THR_LSB])); // [R10]
    end
  end
  assign o_rx_fifo_accept = (i_rx_fifo_level < UIC_FIFO_DEPTH);  // [R11]

  // ---------------------------------------------------------------------------
  // auto-baud result: preset match or dividend minus one
  // ---------------------------------------------------------------------------
  assign bcnt = uic_baud_s'(i_baud_count);  // count/16: upper 12 bits dividend, low 4 remainder

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      baud_r                <= 16'h0000;
      o_brm_load            <= 1'b0;
      o_baud_rate_modulator <= 16'h0000;
    end else begin
      o_brm_load <= i_baud_done;
      if (i_baud_done) begin
        baud_r <= i_baud_count;
        if (ctrl3_r[UIC_C3_BAUD_PRESET_EN] && i_baud_count == match_a_r) begin
          o_baud_rate_modulator <= preset_a_r;                  // [R8]
        end else if (ctrl3_r[UIC_C3_BAUD_PRESET_EN] && i_baud_count == match_b_r) begin
          o_baud_rate_modulator <= preset_b_r;                  // [R8]
        end else begin
          // remainder dropped when presets are off or unmatched
          o_baud_rate_modulator <= {4'h0, bcnt.dividend - 12'h001}; // [R7] [R9]
        end
      end
    end
  end

endmodule : uic_top

// *** tb/uic_top_props.sv ***
// uic_top_props: port assertions for the uart irq/ir control block
`timescale 1ns/1ps
module uic_top_props
  import uic_pkg::*;
(
  // clock, reset and stimulus seen at the ports
  input wire logic               i_core_clk,
  input wire logic               i_sys_rst,
  input wire logic [2:0]         i_ref_div_sel,
  input wire logic               i_rx_pin,
  input wire logic               i_tx_data,
  input wire logic               i_ir_mode,
  input wire uic_pkg::uic_flags_s i_flags,
  input wire logic [5:0]         i_rx_fifo_level,
  input wire logic               i_baud_done,
  // outputs under watch
  input wire logic               o_ref_tick,
  input wire logic               o_ir_tx,
  input wire logic               o_ir_rx_data,
  input wire logic               o_rx_fifo_accept,
  input wire logic               o_brm_load,
  input wire logic               o_tx_irq_line_n,
  input wire logic               o_ctrl_irq_line_n,
  input wire logic               o_rx_irq_line_n
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // ----
  // properties
  // ----
  property p_accept; o_rx_fifo_accept == (i_rx_fifo_level < UIC_FIFO_DEPTH); endproperty
  property p_load; i_baud_done |=> o_brm_load; endproperty
  property p_cause; $rose(o_brm_load) |-> $past(i_baud_done); endproperty
  property p_rx_pass; !i_ir_mode |-> o_ir_rx_data == i_rx_pin; endproperty
  property p_tx_pass; !i_ir_mode |=> o_ir_tx == $past(i_tx_data); endproperty
  // divide by three: two quiet cycles between ticks
  property p_tick3; o_ref_tick && i_ref_div_sel == 3'h3 |=> !o_ref_tick [*2] ##1 o_ref_tick;
  endproperty
  property p_rx_mask; !i_flags.rx_data_ready_flag |=> o_rx_irq_line_n; endproperty
  property p_tx_mask; !i_flags.tx_complete_flag |=> o_tx_irq_line_n; endproperty
  property p_ctrl_mask;
    !(i_flags.break_detect_flag || i_flags.rx_overrun_flag) |=> o_ctrl_irq_line_n;
  endproperty
  a_accept:
    assert property (p_accept) else $error("fifo accept wrong");
  a_load:
    assert property (p_load) else $error("modulator load missing");
  a_cause:
    assert property (p_cause) else $error("modulator load without cause");
  a_rx_pass:
    assert property (p_rx_pass) else $error("rx data not passed through");
  a_tx_pass:
    assert property (p_tx_pass) else $error("tx data not passed through");
  a_tick3:
    assert property (p_tick3) else $error("reference tick spacing wrong");
  a_rx_mask:
    assert property (p_rx_mask) else $error("rx irq without source");
  a_tx_mask:
    assert property (p_tx_mask) else $error("tx irq without source");
  a_ctrl_mask:
    assert property (p_ctrl_mask) else $error("control irq without source");
  c_baud: cover property (i_baud_done);
  c_rx_irq: cover property (!o_rx_irq_line_n);
  c_full: cover property (!o_rx_fifo_accept);
endmodule : uic_top_props

bind uic_top uic_top_props u_props (.*);

// *** tb/uic_ir_partner.sv ***
// uic_ir_partner: infrared transceiver model driving the receive pin
`timescale 1ns/1ps
module uic_ir_partner (
  // clock and pulse request
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic       i_pos,
  input  wire logic [3:0] i_len,
  // receive line towards the block
  output      logic       o_line
);
  logic [3:0] cnt_r = 4'h0;
  // pulse length in clock cycles; longer lengths model a slow transceiver
  always_ff @(posedge i_clk) begin
    if (i_go) cnt_r <= i_len;
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
  end
  // line idles at the inverse of the pulse level
  assign o_line = (cnt_r != 4'h0) ? i_pos : ~i_pos;
endmodule : uic_ir_partner

// *** tb/tb.sv ***
// tb: register, interrupt, flow-control, baud and infrared checks for uic_top
`timescale 1ns/1ps
module tb;
  import uic_pkg::*;
  logic i_core_clk = 1'b0, i_sys_rst = 1'b1, go = 1'b0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic i_awvalid = 0, i_wvalid = 0, i_bready = 1, i_arvalid = 0, i_rready = 1;
  logic [31:0] i_wdata = '0, rd_v, o_rdata;
  logic [3:0] i_wstrb = 4'hf;
  logic [2:0] i_ref_div_sel = 3'h3, o_ref_clk_sel;
  logic i_sample_tick = 1, i_tx_data = 0, i_ir_mode = 0, i_start_bit = 0, i_baud_done = 0;
  logic i_rx_pin, o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_ref_tick, o_ir_tx;
  logic o_ir_rx_data, o_cts_n, o_rx_fifo_accept, o_brm_load, o_tx_irq_line_n;
  logic o_ctrl_irq_line_n, o_rx_irq_line_n, o_async_irq_n;
  logic [1:0] o_bresp, o_rresp, rsp;
  uic_flags_s i_flags = '0;
  logic [5:0] i_rx_fifo_level = '0;
  logic [15:0] i_baud_count = '0, o_baud_rate_modulator;
  logic [31:0] c3t [5] = '{32'h20, 32'h10, 32'h0, 32'h0, 32'h0};
  logic [31:0] c4t [5] = '{32'h0, 32'h0, 32'h80, 32'h120, 32'h0};
  int num_errors = 0, comparisons = 0, n;
  uic_top uut (.*);
  uic_ir_partner u_far (.i_clk(i_core_clk), .i_go(go), .i_pos(1'b0), .i_len(4'h6),
                        .o_line(i_rx_pin));
  always #2 i_core_clk = ~i_core_clk;
  // ----
  // shared tasks
  // ----
  task automatic tally_and_finish();
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic tick(input int k);
    repeat (k) @(posedge i_core_clk);
  endtask : tick
  // bounded wait guard; a hang ends the run
  task automatic guard(input int k);
    if (k >= 50) begin
      num_errors++;
      $display("unexpected at %0t: bus timeout", $time);
      tally_and_finish();
    end
  endtask : guard
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    n = 0;
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    do begin
      tick(1);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      n++;
    end while (!o_bvalid && n < 50);
    guard(n);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    n = 0;
    i_araddr <= a;
    i_arvalid <= 1'b1;
    do begin
      tick(1);
      if (o_arready) i_arvalid <= 1'b0;
      n++;
    end while (!o_rvalid && n < 50);
    rd_v = o_rdata;
    rsp = o_rresp;
    guard(n);
  endtask : rd
  // level drives accept at once and cts one cycle later
  task automatic lvl(input logic [5:0] l, input logic cts, input logic acc);
    i_rx_fifo_level <= l;
    tick(2);
    cmp({o_cts_n, o_rx_fifo_accept}, {cts, acc});
  endtask : lvl
  task automatic baud(input logic [15:0] c, input logic [15:0] e);
    i_baud_count <= c;
    i_baud_done <= 1'b1;
    tick(1);
    i_baud_done <= 1'b0;
    tick(2);
    cmp(o_baud_rate_modulator, e);
  endtask : baud
  // ----
  // main sequence
  // ----
  initial begin
    tick(2);
    i_sys_rst <= 1'b0;
    tick(1);
    cmp({o_tx_irq_line_n, o_ctrl_irq_line_n, o_rx_irq_line_n, o_async_irq_n}, 4'hf);
    rd(UIC_ADDR_CTRL3);
    cmp(rd_v, UIC_CTRL_RST);
    wr(UIC_ADDR_CTRL4, 32'hffff_ffff);
    rd(UIC_ADDR_CTRL4);
    cmp(rd_v, 32'h0000_ffef);
    wr(UIC_ADDR_CTRL3, 32'h0c);
    cmp(o_ref_clk_sel, 3'h7);
    wr(UIC_ADDR_CTRL3, 32'h08);
    cmp(o_ref_clk_sel, 3'h6);
    rd(8'h40);
    cmp(rsp, UIC_RESP_SLVERR);
    i_flags <= 4'hf;
    for (int k = 0; k < 5; k++) begin
      wr(UIC_ADDR_CTRL4, 32'h1 << k);
      tick(2);
      cmp({o_tx_irq_line_n, o_ctrl_irq_line_n, o_rx_irq_line_n},
          3'(~{k == 3, k == 1 || k == 2, k == 0}));
    end
    i_flags <= '0;
    wr(UIC_ADDR_CTRL4, 32'h1400);
    lvl(6'h04, 1'b0, 1'b1);
    lvl(6'h05, 1'b1, 1'b1);
    lvl(6'h1f, 1'b1, 1'b1);
    lvl(6'h20, 1'b1, 1'b0);
    wr(UIC_ADDR_MATCH_A, 32'h0135);
    wr(UIC_ADDR_PRESET_A, 32'habcd);
    wr(UIC_ADDR_MATCH_B, 32'h0240);
    wr(UIC_ADDR_PRESET_B, 32'h1234);
    wr(UIC_ADDR_CTRL3, 32'h0);
    baud(16'h0135, 16'h0012);
    wr(UIC_ADDR_CTRL3, 32'h1);
    baud(16'h0135, 16'habcd);
    baud(16'h0240, 16'h1234);
    baud(16'h0136, 16'h0012);
    // two whole 16-tick periods, so the phase at the start does not matter
    i_ir_mode <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      wr(UIC_ADDR_CTRL3, 32'(p << 1));
      n = 0;
      repeat (32) begin
        tick(1);
        n += int'(o_ir_tx);
      end
      cmp(n, p ? 26 : 6);
    end
    wr(UIC_ADDR_STATUS, 32'hf);
    for (int k = 0; k < 5; k++) begin
      wr(UIC_ADDR_CTRL3, c3t[k]);
      wr(UIC_ADDR_CTRL4, c4t[k]);
      go <= 1'b1;
      i_start_bit <= 1'b1;
      tick(1);
      go <= 1'b0;
      i_start_bit <= 1'b0;
      tick(10);
      cmp(o_async_irq_n, k == 4);
      wr(UIC_ADDR_STATUS, 32'hf);
      tick(2);
      cmp(o_async_irq_n, 1'b1);
    end
    tally_and_finish();
  end
endmodule : tb
